// File: tpdec_top.sv
// Purpose: executes the timer and port transfer group of single-word instructions
// Assumes: the sequencer presents one code per instr_valid pulse with A, B and Y
// Notes: results appear one clock after the issuing edge; timers advance on ticks
// Functional notes
// - the timer-1 read code puts the count's high nibble in B and low nibble in A.
// - the timer-1 write code with the timer stopped loads B:A into count and reload.
// - the timer-1 write code with the timer running loads B:A into the reload only.
// - the timer LC write code copies A into the LC count and the LC reload.
// - the first input read code samples port zero pins into A.
// - the first output write code drives A onto port zero.
// - the second input read code samples port one pins into A.
// - the second output write code drives A onto port one.
// - the third input read code samples port two pins into A, with no output partner.
// - the bit-clear code drives low the bit-port bit chosen by Y for Y from 0 to 7.
// - the bit-set code drives high the bit-port bit chosen by Y for Y from 0 to 7.
// - the pull-up write code copies A into the port-zero pull-up register.
// - the pull-up read code returns the pull-up register in A.
`timescale 1ns/1ps
module tpdec_top #(
  parameter int NIB_W = tpdec_pkg::NIB_W, // data nibble width
  parameter int BITPORT_W = tpdec_pkg::BITPORT_W // bit-output port width
) (
  input wire logic pclk, // instruction clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [tpdec_pkg::APB_AW-1:0] paddr, // apb byte address
  input wire logic [tpdec_pkg::APB_DW-1:0] pwdata, // apb write data
  output logic [tpdec_pkg::APB_DW-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic instr_valid, // one-cycle issue strobe
  input wire logic [tpdec_pkg::CODE_W-1:0] instr_code, // program word
  input wire logic [NIB_W-1:0] acc_in, // accumulator A
  input wire logic [NIB_W-1:0] b_in, // register B
  input wire logic [NIB_W-1:0] y_in, // register Y
  input wire logic [NIB_W-1:0] port_zero_in, // port zero pins
  input wire logic [NIB_W-1:0] port_one_in, // port one pins
  input wire logic [NIB_W-1:0] port_two_in, // port two pins
  input wire logic timer1_tick, // timer 1 count source
  input wire logic lc_tick, // timer LC count source
  output logic acc_load, // load acc_out into A
  output logic [NIB_W-1:0] acc_out, // new A value
  output logic b_load, // load b_out into B
  output logic [NIB_W-1:0] b_out, // new B value
  output logic instr_done, // group instruction finished
  output logic skip_next, // skip request, never raised
  output logic carry_load, // carry update, never raised
  output logic [NIB_W-1:0] port_zero_out, // port zero latch
  output logic [NIB_W-1:0] port_one_out, // port one latch
  output logic [BITPORT_W-1:0] bitport_out, // bit-output port latch
  output logic [NIB_W-1:0] port_zero_pullup_reg, // pull-up enables of port zero
  output logic timer1_underflow // one-cycle underflow pulse
);
  localparam int T1_W = 2 * NIB_W;

  // ****************************************
  // parameter checks
  // ****************************************
  if (NIB_W != tpdec_pkg::NIB_W || BITPORT_W != tpdec_pkg::BITPORT_W) begin : g_bad_param
    $error("tpdec_top: nibble and bit-port widths are fixed by the instruction set");
  end

  // ****************************************
  // helpers
  // ****************************************
  tpdec_dec_if dec ();
  tpdec_bus_if bus ();

  tpdec_decode u_decode (
    .dec(dec)
  );

  tpdec_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus(bus)
  );

  // ****************************************
  // state
  // ****************************************
  logic timer1_run_bit_reg, timer1_run_bit_next;
  logic [T1_W-1:0] timer1_count_reg, timer1_count_next;
  logic [T1_W-1:0] timer1_reload_reg, timer1_reload_next;
  logic [NIB_W-1:0] lc_timer_count_reg, lc_timer_count_next;
  logic [NIB_W-1:0] lc_timer_reload_reg, lc_timer_reload_next;
  logic [NIB_W-1:0] port_zero_reg, port_zero_next;
  logic [NIB_W-1:0] port_one_reg, port_one_next;
  logic [BITPORT_W-1:0] bitport_reg, bitport_next;
  logic [NIB_W-1:0] pullup_reg, pullup_next;
  logic acc_load_reg, acc_load_next;
  logic [NIB_W-1:0] acc_out_reg, acc_out_next;
  logic b_load_reg, b_load_next;
  logic [NIB_W-1:0] b_out_reg, b_out_next;
  logic done_reg, done_next;
  logic uflow_reg, uflow_next;
  tpdec_pkg::tpdec_op_e op;
  logic y_ok;
  logic [2:0] y_sel;

  // ****************************************
  // decode
  // ****************************************
  always_comb begin
    dec.code = instr_code;
    op = instr_valid ? dec.op : tpdec_pkg::OP_NONE;
    y_ok = (y_in < NIB_W'(BITPORT_W));
    y_sel = y_in[2:0];
  end

  // ****************************************
  // timers
  // ****************************************
  // timer 1 and timer LC: loads from instructions, counting on ticks
  always_comb begin
    timer1_count_next = timer1_count_reg;
    timer1_reload_next = timer1_reload_reg;
    lc_timer_count_next = lc_timer_count_reg;
    lc_timer_reload_next = lc_timer_reload_reg;
    uflow_next = 1'b0;
    if (timer1_run_bit_reg && timer1_tick) begin
      if (timer1_count_reg == '0) begin
        timer1_count_next = timer1_reload_reg;
        uflow_next = 1'b1;
      end else begin
        timer1_count_next = timer1_count_reg - 1'b1;
      end
    end
    if (op == tpdec_pkg::OP_WRITE_T1) begin
      timer1_reload_next = {b_in, acc_in};
      if (!timer1_run_bit_reg) begin
        timer1_count_next = {b_in, acc_in};
      end
    end
    if (lc_tick) begin
      lc_timer_count_next = (lc_timer_count_reg == '0) ? lc_timer_reload_reg : lc_timer_count_reg - 1'b1;
    end
    if (op == tpdec_pkg::OP_WRITE_LC) begin
      lc_timer_count_next = acc_in;
      lc_timer_reload_next = acc_in;
    end
  end

  // ****************************************
  // ports and instruction results
  // ****************************************
  // one-cycle execution of the group
  always_comb begin
    port_zero_next = port_zero_reg;
    port_one_next = port_one_reg;
    bitport_next = bitport_reg;
    pullup_next = pullup_reg;
    acc_load_next = 1'b0;
    acc_out_next = acc_out_reg;
    b_load_next = 1'b0;
    b_out_next = b_out_reg;
    done_next = (op != tpdec_pkg::OP_NONE);
    unique case (op)
      tpdec_pkg::OP_READ_T1: begin
        b_load_next = 1'b1;
        b_out_next = timer1_count_reg[T1_W-1:NIB_W];
        acc_load_next = 1'b1;
        acc_out_next = timer1_count_reg[NIB_W-1:0];
      end
      tpdec_pkg::OP_RD_P0: begin
        acc_load_next = 1'b1;
        acc_out_next = port_zero_in;
      end
      tpdec_pkg::OP_WR_P0: begin
        port_zero_next = acc_in;
      end
      tpdec_pkg::OP_RD_P1: begin
        acc_load_next = 1'b1;
        acc_out_next = port_one_in;
      end
      tpdec_pkg::OP_WR_P1: begin
        port_one_next = acc_in;
      end
      tpdec_pkg::OP_RD_P2: begin
        acc_load_next = 1'b1;
        acc_out_next = port_two_in;
      end
      tpdec_pkg::OP_SET_ALL: begin
        bitport_next = tpdec_pkg::BITPORT_ALL;
      end
      tpdec_pkg::OP_CLR_BIT: begin
        if (y_ok) begin
          bitport_next[y_sel] = 1'b0;
        end
      end
      tpdec_pkg::OP_SET_BIT: begin
        if (y_ok) begin
          bitport_next[y_sel] = 1'b1;
        end
      end
      tpdec_pkg::OP_WR_PU: begin
        pullup_next = acc_in;
      end
      tpdec_pkg::OP_RD_PU: begin
        acc_load_next = 1'b1;
        acc_out_next = pullup_reg;
      end
      default: begin
      end
    endcase
  end

  // ****************************************
  // software registers
  // ****************************************
  // run bit written by software, word images for reads
  always_comb begin
    timer1_run_bit_next = timer1_run_bit_reg;
    if (bus.wr_stb && bus.idx == tpdec_pkg::IDX_CTRL) begin
      timer1_run_bit_next = bus.wdata[tpdec_pkg::CTRL_RUN_BIT];
    end
    bus.rd_words[tpdec_pkg::IDX_CTRL] = {31'h0, timer1_run_bit_reg};
    bus.rd_words[tpdec_pkg::IDX_TIMER1] = {16'h0, timer1_reload_reg, timer1_count_reg};
    bus.rd_words[tpdec_pkg::IDX_LC] = {24'h0, lc_timer_reload_reg, lc_timer_count_reg};
    bus.rd_words[tpdec_pkg::IDX_PORTS] = {12'h0, pullup_reg, port_one_reg, port_zero_reg, bitport_reg};
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer1_run_bit_reg <= 1'b0;
      timer1_count_reg <= tpdec_pkg::T1_RESET;
      timer1_reload_reg <= tpdec_pkg::T1_RESET;
      lc_timer_count_reg <= tpdec_pkg::NIB_RESET;
      lc_timer_reload_reg <= tpdec_pkg::NIB_RESET;
      port_zero_reg <= tpdec_pkg::NIB_RESET;
      port_one_reg <= tpdec_pkg::NIB_RESET;
      bitport_reg <= tpdec_pkg::BITPORT_RESET;
      pullup_reg <= tpdec_pkg::NIB_RESET;
      acc_load_reg <= 1'b0;
      acc_out_reg <= tpdec_pkg::NIB_RESET;
      b_load_reg <= 1'b0;
      b_out_reg <= tpdec_pkg::NIB_RESET;
      done_reg <= 1'b0;
      uflow_reg <= 1'b0;
    end else begin
      timer1_run_bit_reg <= timer1_run_bit_next;
      timer1_count_reg <= timer1_count_next;
      timer1_reload_reg <= timer1_reload_next;
      lc_timer_count_reg <= lc_timer_count_next;
      lc_timer_reload_reg <= lc_timer_reload_next;
      port_zero_reg <= port_zero_next;
      port_one_reg <= port_one_next;
      bitport_reg <= bitport_next;
      pullup_reg <= pullup_next;
      acc_load_reg <= acc_load_next;
      acc_out_reg <= acc_out_next;
      b_load_reg <= b_load_next;
      b_out_reg <= b_out_next;
      done_reg <= done_next;
      uflow_reg <= uflow_next;
    end
  end

  // outputs
  always_comb begin
    acc_load = acc_load_reg;
    acc_out = acc_out_reg;
    b_load = b_load_reg;
    b_out = b_out_reg;
    instr_done = done_reg;
    skip_next = 1'b0;
    carry_load = 1'b0;
    port_zero_out = port_zero_reg;
    port_one_out = port_one_reg;
    bitport_out = bitport_reg;
    port_zero_pullup_reg = pullup_reg;
    timer1_underflow = uflow_reg;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_t1_read_split: assert property (
    (op == tpdec_pkg::OP_READ_T1) |=> (b_load && acc_load && {b_out, acc_out} == $past(timer1_count_reg)))
    else $error("timer 1 read did not split the count into B and A");

  a_t1_stop_load: assert property (
    (op == tpdec_pkg::OP_WRITE_T1 && !timer1_run_bit_reg) |=>
    (timer1_count_reg == $past({b_in, acc_in}) && timer1_reload_reg == $past({b_in, acc_in})))
    else $error("stopped timer 1 write did not load count and reload");

  a_t1_run_reload: assert property (
    (op == tpdec_pkg::OP_WRITE_T1 && timer1_run_bit_reg && !timer1_tick) |=>
    (timer1_reload_reg == $past({b_in, acc_in}) && $stable(timer1_count_reg)))
    else $error("running timer 1 write disturbed the count");

  a_lc_write: assert property (
    (op == tpdec_pkg::OP_WRITE_LC) |=> (lc_timer_count_reg == $past(acc_in) && lc_timer_reload_reg == $past(acc_in)))
    else $error("timer LC write did not load both registers");

  a_port_zero_read: assert property (
    (op == tpdec_pkg::OP_RD_P0) |=> (acc_load && acc_out == $past(port_zero_in)))
    else $error("port zero read returned a wrong value");

  a_port_one_read: assert property (
    (op == tpdec_pkg::OP_RD_P1) |=> (acc_load && acc_out == $past(port_one_in)))
    else $error("port one read returned a wrong value");

  a_port_read: assert property (
    (op == tpdec_pkg::OP_RD_P2) |=> (acc_load && acc_out == $past(port_two_in)))
    else $error("port two read returned a wrong value");

  a_port_zero_write: assert property (
    (op == tpdec_pkg::OP_WR_P0) |=> (port_zero_out == $past(acc_in)))
    else $error("port zero write did not take the accumulator");

  // the hold check is waived when a second port one write follows at once
  a_port_write: assert property (
    (op == tpdec_pkg::OP_WR_P1) |=> (port_one_out == $past(acc_in)) ##1
    (port_one_out == $past(acc_in, 2) || $past(op) == tpdec_pkg::OP_WR_P1))
    else $error("port one write did not hold the accumulator");

  a_bit_clear: assert property (
    (op == tpdec_pkg::OP_CLR_BIT && y_ok) |=> (bitport_out[$past(y_sel)] == 1'b0))
    else $error("bit clear left the selected bit high");

  a_bit_set: assert property (
    (op == tpdec_pkg::OP_SET_BIT && y_ok) |=> (bitport_out[$past(y_sel)] == 1'b1))
    else $error("bit set left the selected bit low");

  a_pullup_write: assert property (
    (op == tpdec_pkg::OP_WR_PU) |=> (port_zero_pullup_reg == $past(acc_in)))
    else $error("pull-up write did not take the accumulator");

  a_pullup_read: assert property (
    (op == tpdec_pkg::OP_RD_PU) |=> (acc_load && acc_out == $past(port_zero_pullup_reg)))
    else $error("pull-up read did not return the register");

  a_set_all: assert property (
    (op == tpdec_pkg::OP_SET_ALL) |=> (bitport_out == tpdec_pkg::BITPORT_ALL))
    else $error("set-all did not raise every bit");

  a_one_cycle: assert property (
    instr_valid && (dec.op != tpdec_pkg::OP_NONE) |=> instr_done && !skip_next && !carry_load)
    else $error("group instruction did not finish in one cycle");
endmodule // tpdec_top

// File: tpdec_pkg.sv
// Purpose: shared constants and types of the timer/port transfer decoder
// Assumes: 10-bit instruction words, 4-bit data path, 32-bit APB data
// Notes: every code and offset, and the timer, nibble and bit-port reset values used by the decoder, live here
package tpdec_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int NIB_W = 4;
  localparam int CODE_W = 10;
  localparam int BITPORT_W = 8;
  localparam int T1_W = 2 * NIB_W;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int REG_N = 4;
  localparam int IDX_W = 2;

  // ****************************************
  // instruction codes
  // ****************************************
  localparam logic [CODE_W-1:0] CODE_READ_T1 = 10'h270;
  localparam logic [CODE_W-1:0] CODE_WRITE_T1 = 10'h230;
  localparam logic [CODE_W-1:0] CODE_WRITE_LC = 10'h20d;
  localparam logic [CODE_W-1:0] CODE_RD_P0 = 10'h260;
  localparam logic [CODE_W-1:0] CODE_WR_P0 = 10'h220;
  localparam logic [CODE_W-1:0] CODE_RD_P1 = 10'h261;
  localparam logic [CODE_W-1:0] CODE_WR_P1 = 10'h221;
  localparam logic [CODE_W-1:0] CODE_RD_P2 = 10'h262;
  localparam logic [CODE_W-1:0] CODE_SET_ALL = 10'h011;
  localparam logic [CODE_W-1:0] CODE_CLR_BIT = 10'h014;
  localparam logic [CODE_W-1:0] CODE_SET_BIT = 10'h015;
  localparam logic [CODE_W-1:0] CODE_WR_PU = 10'h22d;
  localparam logic [CODE_W-1:0] CODE_RD_PU = 10'h257;

  // decoded operation, one-hot
  typedef enum logic [13:0] {
    OP_NONE = 14'h0001,
    OP_READ_T1 = 14'h0002,
    OP_WRITE_T1 = 14'h0004,
    OP_WRITE_LC = 14'h0008,
    OP_RD_P0 = 14'h0010,
    OP_WR_P0 = 14'h0020,
    OP_RD_P1 = 14'h0040,
    OP_WR_P1 = 14'h0080,
    OP_RD_P2 = 14'h0100,
    OP_SET_ALL = 14'h0200,
    OP_CLR_BIT = 14'h0400,
    OP_SET_BIT = 14'h0800,
    OP_WR_PU = 14'h1000,
    OP_RD_PU = 14'h2000
  } tpdec_op_e;

  // ****************************************
  // register map and reset values
  // ****************************************
  localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] ADDR_TIMER1 = 12'h004;
  localparam logic [APB_AW-1:0] ADDR_LC = 12'h008;
  localparam logic [APB_AW-1:0] ADDR_PORTS = 12'h00c;
  localparam logic [IDX_W-1:0] IDX_CTRL = 2'h0;
  localparam logic [IDX_W-1:0] IDX_TIMER1 = 2'h1;
  localparam logic [IDX_W-1:0] IDX_LC = 2'h2;
  localparam logic [IDX_W-1:0] IDX_PORTS = 2'h3;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic [T1_W-1:0] T1_RESET = 8'h00;
  localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
  localparam logic [BITPORT_W-1:0] BITPORT_RESET = 8'h00;
  localparam logic [BITPORT_W-1:0] BITPORT_ALL = 8'hff;
endpackage

// File: tpdec_ifs.sv
// Purpose: carriers between the decoder core and its two helper modules
// Assumes: tpdec_pkg compiled first
// Notes: one interface per helper
`timescale 1ns/1ps
interface tpdec_dec_if;
  logic [tpdec_pkg::CODE_W-1:0] code;
  tpdec_pkg::tpdec_op_e op;
  modport decoder (input code, output op);
  modport user (output code, input op);
endinterface

interface tpdec_bus_if;
  logic wr_stb;
  logic [tpdec_pkg::IDX_W-1:0] idx;
  logic [tpdec_pkg::APB_DW-1:0] wdata;
  logic [tpdec_pkg::REG_N-1:0][tpdec_pkg::APB_DW-1:0] rd_words;
  modport slave (output wr_stb, idx, wdata, input rd_words);
  modport core (input wr_stb, idx, wdata, output rd_words);
endinterface

// File: tpdec_decode.sv
// Purpose: maps a 10-bit program word onto a one-hot operation
// Assumes: pure combinational, codes outside the group give OP_NONE
// Notes: shared by execution and checking in the core
`timescale 1ns/1ps
module tpdec_decode (
  tpdec_dec_if.decoder dec // code in, operation out
);
  // ****************************************
  // decode table
  // ****************************************
  function automatic tpdec_pkg::tpdec_op_e tpdec_lookup(input logic [tpdec_pkg::CODE_W-1:0] c);
    unique case (c)
      tpdec_pkg::CODE_READ_T1: tpdec_lookup = tpdec_pkg::OP_READ_T1;
      tpdec_pkg::CODE_WRITE_T1: tpdec_lookup = tpdec_pkg::OP_WRITE_T1;
      tpdec_pkg::CODE_WRITE_LC: tpdec_lookup = tpdec_pkg::OP_WRITE_LC;
      tpdec_pkg::CODE_RD_P0: tpdec_lookup = tpdec_pkg::OP_RD_P0;
      tpdec_pkg::CODE_WR_P0: tpdec_lookup = tpdec_pkg::OP_WR_P0;
      tpdec_pkg::CODE_RD_P1: tpdec_lookup = tpdec_pkg::OP_RD_P1;
      tpdec_pkg::CODE_WR_P1: tpdec_lookup = tpdec_pkg::OP_WR_P1;
      tpdec_pkg::CODE_RD_P2: tpdec_lookup = tpdec_pkg::OP_RD_P2;
      tpdec_pkg::CODE_SET_ALL: tpdec_lookup = tpdec_pkg::OP_SET_ALL;
      tpdec_pkg::CODE_CLR_BIT: tpdec_lookup = tpdec_pkg::OP_CLR_BIT;
      tpdec_pkg::CODE_SET_BIT: tpdec_lookup = tpdec_pkg::OP_SET_BIT;
      tpdec_pkg::CODE_WR_PU: tpdec_lookup = tpdec_pkg::OP_WR_PU;
      tpdec_pkg::CODE_RD_PU: tpdec_lookup = tpdec_pkg::OP_RD_PU;
      default: tpdec_lookup = tpdec_pkg::OP_NONE;
    endcase
  endfunction

  // table lookup
  always_comb begin
    dec.op = tpdec_lookup(dec.code);
  end
endmodule // tpdec_decode

// File: tpdec_apb.sv
// Purpose: APB slave front end of the decoder's status/control registers
// Assumes: APB3 signalling, zero wait states
// Notes: read data is captured in the setup phase so it leaves a flip-flop
`timescale 1ns/1ps
module tpdec_apb (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // slave select
  input wire logic penable, // access phase
  input wire logic pwrite, // write direction
  input wire logic [tpdec_pkg::APB_AW-1:0] paddr, // byte address
  input wire logic [tpdec_pkg::APB_DW-1:0] pwdata, // write data
  output logic [tpdec_pkg::APB_DW-1:0] prdata, // read data
  output logic pready, // always ready
  output logic pslverr, // unmapped access
  tpdec_bus_if.slave bus // towards the core
);
  logic [tpdec_pkg::APB_DW-1:0] prdata_reg;
  logic [tpdec_pkg::APB_DW-1:0] prdata_next;
  logic hit;

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic tpdec_mapped(input logic [tpdec_pkg::APB_AW-1:0] a);
    tpdec_mapped = (a == tpdec_pkg::ADDR_CTRL) || (a == tpdec_pkg::ADDR_TIMER1) ||
                   (a == tpdec_pkg::ADDR_LC) || (a == tpdec_pkg::ADDR_PORTS);
  endfunction

  // strobes and index towards the core
  always_comb begin
    hit = tpdec_mapped(paddr);
    bus.idx = paddr[tpdec_pkg::IDX_W+1:2];
    bus.wdata = pwdata;
    bus.wr_stb = psel && penable && pwrite && hit;
    pready = 1'b1;
    pslverr = psel && penable && !hit;
    prdata = prdata_reg;
  end

  // read word captured during setup, zero for unmapped
  always_comb begin
    prdata_next = prdata_reg;
    if (psel && !penable) begin
      prdata_next = hit ? bus.rd_words[bus.idx] : '0;
    end
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else begin
      prdata_reg <= prdata_next;
    end
  end
endmodule // tpdec_apb

// File: tpdec_seq_model.sv
// Purpose: instruction sequencer model that issues one program word at a time
// Assumes: tpdec_pkg compiled first
// Notes: lines change only right after a rising edge
`timescale 1ns/1ps
module tpdec_seq_model (
  input wire logic pclk, // instruction clock
  output logic instr_valid, // issue strobe
  output logic [tpdec_pkg::CODE_W-1:0] instr_code, // program word
  output logic [tpdec_pkg::NIB_W-1:0] acc_in, // register a
  output logic [tpdec_pkg::NIB_W-1:0] b_in, // register b
  output logic [tpdec_pkg::NIB_W-1:0] y_in // register y
);
  // idle lines start low
  initial begin
    instr_valid = 1'b0;
    instr_code = 10'h000;
    acc_in = 4'h0;
    b_in = 4'h0;
    y_in = 4'h0;
  end
  // one word per strobe; released lines show the inverse of the last value
  task automatic issue(input logic [9:0] c, input logic [3:0] a, input logic [3:0] b, input logic [3:0] y);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_code <= c;
    acc_in <= a;
    b_in <= b;
    y_in <= y;
    @(posedge pclk);
    instr_valid <= 1'b0;
    instr_code <= ~c;
    acc_in <= ~a;
    b_in <= ~b;
    y_in <= ~y;
  endtask
endmodule // tpdec_seq_model

// File: tb_timer_port_transfer_decode.sv
// Purpose: self-checking bench of the timer and port transfer decoder
// Assumes: tpdec_pkg, tpdec_ifs and the design compiled first
// Notes: timer ticks held low so counts stay where they were loaded, until a final 16-cycle burst of both ticks
`timescale 1ns/1ps
module tb_timer_port_transfer_decode;
  // ****************************************
  // signals and instances
  // ****************************************
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, instr_valid, timer1_tick, lc_tick;
  logic acc_load, b_load, instr_done, skip_next, carry_load, timer1_underflow, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] instr_code;
  logic [3:0] acc_in, b_in, y_in, port_zero_in, port_one_in, port_two_in, acc_out, b_out;
  logic [3:0] port_zero_out, port_one_out, port_zero_pullup_reg, a, b, pz, po, pt;
  logic [7:0] bitport_out, dexp;
  logic s;
  int err_total = 0;
  int cmp_count = 0;
  always #20 pclk = ~pclk;
  tpdec_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .instr_valid, .instr_code, .acc_in, .b_in, .y_in, .port_zero_in, .port_one_in,
    .port_two_in, .timer1_tick, .lc_tick, .acc_load, .acc_out, .b_load, .b_out, .instr_done,
    .skip_next, .carry_load, .port_zero_out, .port_one_out, .bitport_out, .port_zero_pullup_reg,
    .timer1_underflow);
  tpdec_seq_model i_seq (.pclk, .instr_valid, .instr_code, .acc_in, .b_in, .y_in);
  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // value comparison
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // apb transfer, result left in rd and er
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one instruction and its completion flags
  task automatic run(input logic [9:0] c, input logic [3:0] ra, input logic [3:0] y, input logic d);
    i_seq.issue(c, ra, ~ra, y);
    #1;
    chk("instr_done", {31'h0, d}, {31'h0, instr_done});
    chk("skip_carry", 32'h0, {30'h0, skip_next, carry_load});
  endtask
  // expected timer 1 word: reload above count
  function automatic logic [31:0] t1_word(input logic [7:0] rl, input logic [7:0] cn);
    return {16'h0000, rl, cn};
  endfunction
  // expected timer LC count after n ticks from a load of rl
  function automatic logic [3:0] lc_after(input logic [3:0] rl, input int n);
    logic [3:0] c;
    c = rl;
    repeat (n) c = (c == 4'h0) ? rl : c - 4'h1;
    return c;
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rd = $urandom(32'h6c95);
    {presetn, psel, penable, pwrite, timer1_tick, lc_tick, paddr, pwdata} = '0;
    {port_zero_in, port_one_in, port_two_in} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, tpdec_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    a = $urandom;
    b = ~a;
    run(tpdec_pkg::CODE_WRITE_T1, a, 4'h0, 1'b1);
    apb(1'b0, tpdec_pkg::ADDR_TIMER1, 32'h0);
    chk("t1_stopped", t1_word({b, a}, {b, a}), rd);
    run(tpdec_pkg::CODE_READ_T1, b, 4'h0, 1'b1);
    chk("t1_read", {22'h0, 1'b1, b, 1'b1, a}, {22'h0, b_load, b_out, acc_load, acc_out});
    apb(1'b1, tpdec_pkg::ADDR_CTRL, 32'h1);
    run(tpdec_pkg::CODE_WRITE_T1, b, 4'h0, 1'b1);
    apb(1'b1, tpdec_pkg::ADDR_TIMER1, 32'hffff_ffff);
    apb(1'b0, tpdec_pkg::ADDR_TIMER1, 32'h0);
    chk("t1_running", t1_word({a, b}, {b, a}), rd);
    apb(1'b1, tpdec_pkg::ADDR_CTRL, 32'h0);
    run(tpdec_pkg::CODE_WRITE_LC, a, 4'h0, 1'b1);
    apb(1'b0, tpdec_pkg::ADDR_LC, 32'h0);
    chk("lc_word", {24'h0, a, a}, rd);
    pz = $urandom;
    po = $urandom;
    pt = $urandom;
    port_zero_in <= pz;
    port_one_in <= po;
    port_two_in <= pt;
    run(tpdec_pkg::CODE_RD_P0, ~pz, 4'h0, 1'b1);
    chk("rd_p0", {27'h0, 1'b1, pz}, {27'h0, acc_load, acc_out});
    run(tpdec_pkg::CODE_RD_P1, ~po, 4'h0, 1'b1);
    chk("rd_p1", {27'h0, 1'b1, po}, {27'h0, acc_load, acc_out});
    run(tpdec_pkg::CODE_RD_P2, ~pt, 4'h0, 1'b1);
    chk("rd_p2", {27'h0, 1'b1, pt}, {27'h0, acc_load, acc_out});
    run(tpdec_pkg::CODE_WR_P0, pz, 4'h0, 1'b1);
    run(tpdec_pkg::CODE_WR_P1, ~pz, 4'h0, 1'b1);
    chk("port_outs", {24'h0, ~pz, pz}, {24'h0, port_one_out, port_zero_out});
    run(tpdec_pkg::CODE_WR_PU, po, 4'h0, 1'b1);
    run(tpdec_pkg::CODE_RD_PU, ~po, 4'h0, 1'b1);
    chk("pullup", {24'h0, po, po}, {24'h0, port_zero_pullup_reg, acc_out});
    run(tpdec_pkg::CODE_SET_ALL, 4'h0, 4'h0, 1'b1);
    chk("set_all", 32'hff, {24'h0, bitport_out});
    dexp = 8'hff;
    for (int i = 0; i < 16; i++) begin
      s = $urandom;
      run(s ? tpdec_pkg::CODE_SET_BIT : tpdec_pkg::CODE_CLR_BIT, 4'h0, 4'(i), 1'b1);
      if (i < 8) dexp[i] = s;
      chk("bitport", {24'h0, dexp}, {24'h0, bitport_out});
    end
    run(tpdec_pkg::CODE_WRITE_T1, 4'hf, 4'h0, 1'b1);
    apb(1'b1, tpdec_pkg::ADDR_CTRL, 32'h1);
    {timer1_tick, lc_tick} <= 2'b11;
    repeat (16) @(posedge pclk);
    {timer1_tick, lc_tick} <= 2'b00;
    #1;
    chk("t1_uflow", 32'h1, {31'h0, timer1_underflow});
    apb(1'b0, tpdec_pkg::ADDR_TIMER1, 32'h0);
    chk("t1_wrap", t1_word(8'h0f, 8'h0f), rd);
    apb(1'b0, tpdec_pkg::ADDR_LC, 32'h0);
    chk("lc_ticks", {24'h0, a, lc_after(a, 16)}, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    chk("unmapped_rd", 32'h0, rd);
    run(10'h3ff, 4'h0, 4'h0, 1'b0);
    stop_test();
  end
endmodule // tb_timer_port_transfer_decode
